// ### serial_irq_pkg.sv
// Package: register map, field positions and reset values of the serial interrupt block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package serial_irq_pkg;
	localparam logic [7:0]  IRQ_ENABLE_OFS     = 8'h38;
	localparam logic [7:0]  IRQ_RAW_OFS        = 8'h3c;
	localparam logic [7:0]  IRQ_MASKED_OFS     = 8'h40;
	localparam int          RECEIVE_BIT        = 4;
	localparam int          TRANSMIT_BIT       = 5;
	localparam int          RX_TIMEOUT_BIT     = 6;
	localparam int          FRAMING_BIT        = 7;
	localparam int          PARITY_BIT         = 8;
	localparam int          BREAK_BIT          = 9;
	localparam int          OVERRUN_BIT        = 10;
	localparam int          SRC_LO             = 4;
	localparam int          SRC_HI             = 10;
	localparam int          SRC_N              = 7;
	localparam logic [6:0]  ENABLE_RESET       = 7'h00;
	localparam logic [3:0]  RAW_RESERVED_VALUE = 4'hf;
	localparam logic [3:0]  ENA_RESERVED_VALUE = 4'h0;
	localparam logic [31:0] UNMAPPED_READ      = 32'h00000000;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;
endpackage : serial_irq_pkg

// ### serial_irq_gate.sv
// Gate: masks raw pending sources by their enables, registered.
// Assumes sources and enables are on sys_clk already.
`timescale 1ns/1ps
module serial_irq_gate (
	input  wire logic                                sys_clk,
	input  wire logic                                rst,
	input  wire logic [serial_irq_pkg::SRC_N-1:0]    raw,
	input  wire logic [serial_irq_pkg::SRC_N-1:0]    enable,
	output logic      [serial_irq_pkg::SRC_N-1:0]    masked
);
	import serial_irq_pkg::*;
	typedef struct packed {
		logic [SRC_N-1:0] masked;
	} gate_state_t;
	gate_state_t state_reg;
	gate_state_t state_next;
	always_comb begin
		state_next = state_reg;
		state_next.masked = raw & enable;
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign masked = state_reg.masked;
endmodule : serial_irq_gate

// ### serial_irq_regs.sv
// Top: serial port interrupt enable, raw and masked pending registers on Avalon-MM.
// Assumes event sources are levels on sys_clk; the interrupt controller takes irq_out.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - The enable register sits at byte offset 0x038 and its enable fields read and write.
// - Transmit enable bit 5 forwards the transmit event when 1 and resets to 0.
// - Receive enable bit 4 forwards the receive event when 1 and resets to 0.
// - Reading an enable field returns the enable in force for that source.
// - Enable bits 3:0 are reserved, ignore writes, and software must preserve them.
// - The raw pending register at 0x03C returns every source's unmasked state.
// - Writes to the raw pending register change nothing.
// - The read-only masked register at 0x040 shows raw pending gated by enable.
// - Raw pending bit 5 is the read-only transmit pending state, reset 0.
module serial_irq_regs (
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	input  wire logic [7:0]                       avs_address,
	input  wire logic                             avs_read,
	input  wire logic                             avs_write,
	input  wire logic [31:0]                      avs_writedata,
	input  wire logic [3:0]                       avs_byteenable,
	output logic      [31:0]                      avs_readdata,
	output logic                                  avs_waitrequest,
	input  wire logic [serial_irq_pkg::SRC_N-1:0] src_pending,
	output logic      [serial_irq_pkg::SRC_N-1:0] irq_out
);
	import serial_irq_pkg::*;
	typedef struct packed {
		bus_state_t       bus;
		logic             waiting;
		logic [SRC_N-1:0] enable;
		logic [SRC_N-1:0] raw;
		logic [31:0]      rdata;
	} regs_state_t;
	regs_state_t      state_reg;
	regs_state_t      state_next;
	logic [SRC_N-1:0] masked;

	function automatic logic [31:0] place(input logic [SRC_N-1:0] v, input logic [3:0] low);
		place = {21'h000000, v, low};
	endfunction : place

	serial_irq_gate i_serial_irq_gate (
		.sys_clk (sys_clk),
		.rst     (rst),
		.raw     (state_reg.raw),
		.enable  (state_reg.enable),
		.masked  (masked)
	);

	always_comb begin
		state_next = state_reg;
		// Sources sampled once so raw and masked reads stay coherent
		state_next.raw = src_pending;
		case (state_reg.bus)
			BUS_IDLE: begin
				if (avs_write) begin
					state_next.bus = BUS_ANSWER;
					// Only byte 0 and byte 1 carry enable bits; raw and masked ignore writes
					if (avs_address == IRQ_ENABLE_OFS) begin
						if (avs_byteenable[0]) begin
							state_next.enable[3:0] = avs_writedata[7:4];
						end
						if (avs_byteenable[1]) begin
							state_next.enable[6:4] = avs_writedata[10:8];
						end
					end
				end else if (avs_read) begin
					state_next.bus = BUS_ANSWER;
					case (avs_address)
						IRQ_ENABLE_OFS: state_next.rdata = place(state_reg.enable,
							ENA_RESERVED_VALUE);
						IRQ_RAW_OFS:    state_next.rdata = place(state_reg.raw,
							RAW_RESERVED_VALUE);
						IRQ_MASKED_OFS: state_next.rdata = place(masked, 4'h0);
						default:        state_next.rdata = UNMAPPED_READ;
					endcase
				end
			end
			BUS_ANSWER: begin
				state_next.bus = BUS_IDLE;
			end
			default: begin
				state_next.bus = BUS_IDLE;
			end
		endcase
		// Waitrequest registered with the state; low only in the answer cycle
		state_next.waiting = (state_next.bus != BUS_ANSWER);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '{bus: BUS_IDLE, waiting: 1'b1, enable: ENABLE_RESET,
				raw: '0, rdata: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign avs_waitrequest = state_reg.waiting;
	assign avs_readdata    = state_reg.rdata;
	assign irq_out         = masked;

	AST_TX_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		##1 !state_reg.enable[TRANSMIT_BIT-SRC_LO] |=> !irq_out[TRANSMIT_BIT-SRC_LO])
		else $error("transmit event passed while disabled");
	AST_RX_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.enable[RECEIVE_BIT-SRC_LO] && state_reg.raw[RECEIVE_BIT-SRC_LO]
		|=> irq_out[RECEIVE_BIT-SRC_LO])
		else $error("enabled receive event not forwarded");
	AST_RT_GATE: assert property (@(posedge sys_clk) disable iff (rst)
		##1 irq_out[RX_TIMEOUT_BIT-SRC_LO] |-> $past(state_reg.enable[RX_TIMEOUT_BIT-SRC_LO]))
		else $error("timeout event forwarded while disabled");
	sequence enable_write_s;
		state_reg.bus == BUS_IDLE && avs_write && avs_address == IRQ_ENABLE_OFS
		&& avs_byteenable[1];
	endsequence
	AST_ENA_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		enable_write_s |=> state_reg.enable[6:4] == $past(avs_writedata[10:8]))
		else $error("enable write not stored");
	AST_ENA_READ: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.bus == BUS_IDLE && avs_read && !avs_write && avs_address == IRQ_ENABLE_OFS
		|=> avs_readdata[10:4] == state_reg.enable && !avs_waitrequest)
		else $error("enable readback wrong");
	AST_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
		##1 state_reg.bus == BUS_ANSWER && avs_address == IRQ_ENABLE_OFS
		|-> avs_readdata[31:11] == 21'h000000)
		else $error("enable upper bits not zero");
	AST_RAW_READ: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.bus == BUS_IDLE && avs_read && !avs_write && avs_address == IRQ_RAW_OFS
		|=> avs_readdata[10:4] == $past(state_reg.raw))
		else $error("raw read wrong");
	AST_RAW_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.bus == BUS_IDLE && avs_write && avs_address != IRQ_ENABLE_OFS
		|=> $stable(state_reg.enable))
		else $error("write outside enable changed state");
	AST_MASKED: assert property (@(posedge sys_clk) disable iff (rst)
		##1 masked == ($past(state_reg.raw) & $past(state_reg.enable)))
		else $error("masked state wrong");
	AST_TX_RAW: assert property (@(posedge sys_clk) disable iff (rst)
		##1 state_reg.raw[TRANSMIT_BIT-SRC_LO] == $past(src_pending[TRANSMIT_BIT-SRC_LO]))
		else $error("transmit pending not tracked");

	// Handshake: exactly one answer cycle, then the slave waits again
	sequence bus_taken_s;
		state_reg.bus == BUS_IDLE && (avs_read || avs_write);
	endsequence
	sequence answer_s;
		state_reg.bus == BUS_ANSWER && !avs_waitrequest;
	endsequence
	sequence back_idle_s;
		state_reg.bus == BUS_IDLE && avs_waitrequest;
	endsequence
	AST_BUS_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
		bus_taken_s |=> answer_s ##1 back_idle_s)
		else $error("bus answer timing wrong");

	// First edge after reset leaves every source withheld
	sequence reset_left_s;
		$fell(rst);
	endsequence
	AST_RESET_VAL: assert property (@(posedge sys_clk) disable iff (rst)
		reset_left_s |-> state_reg.enable == ENABLE_RESET && state_reg.raw == '0
		&& irq_out == '0 && avs_waitrequest)
		else $error("state after reset wrong");

	// Forwarding and withholding per source, one cycle through the gate
	AST_RX_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
		!state_reg.enable[RECEIVE_BIT-SRC_LO] |=> !irq_out[RECEIVE_BIT-SRC_LO])
		else $error("receive event passed while disabled");
	AST_TX_FORWARD: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.enable[TRANSMIT_BIT-SRC_LO] && state_reg.raw[TRANSMIT_BIT-SRC_LO]
		|=> irq_out[TRANSMIT_BIT-SRC_LO])
		else $error("enabled transmit event not forwarded");
	AST_RT_FORWARD: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.enable[RX_TIMEOUT_BIT-SRC_LO] && state_reg.raw[RX_TIMEOUT_BIT-SRC_LO]
		|=> irq_out[RX_TIMEOUT_BIT-SRC_LO])
		else $error("enabled timeout event not forwarded");

	// Byte lanes: a lane left out keeps its enables
	sequence enable_low_write_s;
		state_reg.bus == BUS_IDLE && avs_write && avs_address == IRQ_ENABLE_OFS
		&& avs_byteenable[0];
	endsequence
	AST_ENA_LOW_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		enable_low_write_s |=> state_reg.enable[3:0] == $past(avs_writedata[7:4]))
		else $error("lower enable write not stored");
	sequence enable_lane_skip_s;
		state_reg.bus == BUS_IDLE && avs_write && avs_address == IRQ_ENABLE_OFS
		&& !avs_byteenable[1];
	endsequence
	AST_ENA_LANE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		enable_lane_skip_s |=> $stable(state_reg.enable[6:4]))
		else $error("unselected lane changed enables");

	// Read decode, reserved nibbles and side effects
	sequence any_read_s;
		state_reg.bus == BUS_IDLE && avs_read && !avs_write;
	endsequence
	sequence enable_read_s;
		state_reg.bus == BUS_IDLE && avs_read && !avs_write && avs_address == IRQ_ENABLE_OFS;
	endsequence
	sequence raw_read_s;
		state_reg.bus == BUS_IDLE && avs_read && !avs_write && avs_address == IRQ_RAW_OFS;
	endsequence
	sequence masked_read_s;
		state_reg.bus == BUS_IDLE && avs_read && !avs_write && avs_address == IRQ_MASKED_OFS;
	endsequence
	AST_ENA_READ_KEEP: assert property (@(posedge sys_clk) disable iff (rst)
		any_read_s |=> $stable(state_reg.enable))
		else $error("read changed enables");
	AST_ENA_RES_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		enable_read_s |=> avs_readdata[3:0] == ENA_RESERVED_VALUE)
		else $error("enable reserved bits wrong");
	AST_RAW_RES_LOW: assert property (@(posedge sys_clk) disable iff (rst)
		raw_read_s |=> avs_readdata[3:0] == RAW_RESERVED_VALUE)
		else $error("raw reserved bits wrong");
	AST_MASKED_READ: assert property (@(posedge sys_clk) disable iff (rst)
		masked_read_s |=> avs_readdata[10:4] == $past(masked) && avs_readdata[3:0] == 4'h0)
		else $error("masked read wrong");
	AST_TX_RAW_READ: assert property (@(posedge sys_clk) disable iff (rst)
		raw_read_s |=> avs_readdata[TRANSMIT_BIT] == $past(state_reg.raw[TRANSMIT_BIT-SRC_LO]))
		else $error("transmit pending read wrong");
	AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg.bus == BUS_IDLE && avs_read && !avs_write && avs_address != IRQ_ENABLE_OFS
		&& avs_address != IRQ_RAW_OFS && avs_address != IRQ_MASKED_OFS
		|=> avs_readdata == UNMAPPED_READ)
		else $error("unmapped read not zero");

	// Raw pending keeps tracking its sources through a write to it
	sequence raw_write_s;
		state_reg.bus == BUS_IDLE && avs_write && avs_address == IRQ_RAW_OFS;
	endsequence
	AST_RAW_KEEPS: assert property (@(posedge sys_clk) disable iff (rst)
		raw_write_s |=> state_reg.raw == $past(src_pending) && $stable(state_reg.enable))
		else $error("raw write disturbed state");
endmodule : serial_irq_regs

// ### serial_irq_regs_test.sv
// Testbench: register reads and writes plus masked interrupt lines of serial_irq_regs.
// Assumes the design package is compiled first; no external partner.
`timescale 1ns/1ps
module serial_irq_regs_test;
	import serial_irq_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [6:0]  src_pending = 7'h00;
	logic [6:0]  irq_out;
	logic [31:0] q;
	int          failures = 0;
	int          checks_done = 0;

	serial_irq_regs i_serial_irq_regs (
		.sys_clk         (sys_clk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.src_pending     (src_pending),
		.irq_out         (irq_out)
	);

	always #12.5 sys_clk = ~sys_clk;

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Holds the request until waitrequest is sampled low; idles one edge after
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		q = avs_readdata;
		if (n >= 50) begin
			failures++;
			conclude();
		end else begin
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge sys_clk);
		end
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(what, q, exp);
	endtask : rd

	// Masked lines lag sources by two cycles
	task automatic irq_is(input logic [6:0] exp);
		repeat (3) @(posedge sys_clk);
		check("irq_out", {25'h0, irq_out}, {25'h0, exp});
	endtask : irq_is

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(IRQ_ENABLE_OFS, 32'h00000000, "enable reset");
		rd(IRQ_RAW_OFS, 32'h0000000f, "raw reset");
		rd(IRQ_MASKED_OFS, 32'h00000000, "masked reset");
		$display("test reset done");
		src_pending <= 7'h7f;
		irq_is(7'h00);
		// Bits 3:0 written back as read, zero
		bus(1'b1, IRQ_ENABLE_OFS, 32'h000007f0);
		rd(IRQ_ENABLE_OFS, 32'h000007f0, "enable all");
		irq_is(7'h7f);
		bus(1'b1, IRQ_ENABLE_OFS, 32'h00000020);
		irq_is(7'h02);
		rd(IRQ_MASKED_OFS, 32'h00000020, "masked tx");
		rd(IRQ_RAW_OFS, 32'h000007ff, "raw all");
		$display("test transmit done");
		bus(1'b1, IRQ_RAW_OFS, 32'h00000000);
		rd(IRQ_RAW_OFS, 32'h000007ff, "raw after write");
		rd(IRQ_ENABLE_OFS, 32'h00000020, "enable kept");
		bus(1'b1, IRQ_ENABLE_OFS, 32'h00000050);
		src_pending <= 7'h05;
		irq_is(7'h05);
		rd(IRQ_RAW_OFS, 32'h0000005f, "raw partial");
		rd(8'h44, UNMAPPED_READ, "unmapped");
		$display("test receive done");
		avs_byteenable <= 4'h2;
		bus(1'b1, IRQ_ENABLE_OFS, 32'h000007f0);
		rd(IRQ_ENABLE_OFS, 32'h00000750, "enable upper lane");
		avs_byteenable <= 4'h1;
		bus(1'b1, IRQ_ENABLE_OFS, 32'h00000020);
		avs_byteenable <= 4'hf;
		rd(IRQ_ENABLE_OFS, 32'h00000720, "enable lower lane");
		irq_is(7'h00);
		$display("test byte lanes done");
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(IRQ_ENABLE_OFS, 32'h00000000, "enable after reset");
		irq_is(7'h00);
		rd(IRQ_RAW_OFS, 32'h0000005f, "raw after reset");
		$display("test reset again done");
		conclude();
	end
endmodule : serial_irq_regs_test
